/* File: design/sbd_core.sv */
// Subtract-with-borrow and decrement-and-skip execution datapath.
`timescale 1ns/1ps
module sbd_core (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire sbd_pkg::sbd_req_type i_req,
    output sbd_pkg::sbd_mem_wr_type o_mem_wr,
    output logic [7:0] o_working_register,
    output sbd_pkg::sbd_flags_type o_flags,
    output logic o_skip,
    output logic o_dummy_cycle,
    output logic o_busy
);
    // ************************************************************
    // Sequencer states
    // ************************************************************
    // A taken skip parks the sequencer for one dummy cycle while the
    // next instruction is fetched and thrown away.
    typedef enum {
        SBD_SEQ_EXEC,
        SBD_SEQ_DUMMY
    } sbd_seq_type;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] wreg_reg;
    logic [7:0] wreg_next;
    sbd_pkg::sbd_flags_type flags_reg;
    sbd_pkg::sbd_flags_type flags_next;
    sbd_seq_type seq_reg;
    sbd_seq_type seq_next;
    logic take;
    logic take_sub;
    logic take_dec_mem;
    logic take_dec_wreg;
    logic take_dec;
    logic take_skip;
    logic borrow_in;
    logic [8:0] diff_wide;
    logic [4:0] low_wide;
    logic [7:0] diff;
    logic diff_null;
    logic ovf;
    logic [7:0] dec_result;
    logic dec_null;

    // ************************************************************
    // Request decode
    // ************************************************************
    // A request is only taken outside the dummy cycle; one that arrives
    // during it is dropped without a trace, as the fetch is discarded.
    assign take = i_req.valid && (seq_reg == SBD_SEQ_EXEC);

    always_comb begin
        take_sub = 1'b0;
        take_dec_mem = 1'b0;
        take_dec_wreg = 1'b0;
        if (take && i_req.op == sbd_pkg::SBD_OP_SUB_BORROW_MEM) begin
            take_sub = 1'b1;
        end else if (take && i_req.op == sbd_pkg::SBD_OP_DEC_SKIP_MEM) begin
            take_dec_mem = 1'b1;
        end else if (take && i_req.op == sbd_pkg::SBD_OP_DEC_SKIP_WREG) begin
            take_dec_wreg = 1'b1;
        end
    end

    assign take_dec = take_dec_mem || take_dec_wreg;
    assign take_skip = take_dec && dec_null;

    // ************************************************************
    // Subtract with borrow
    // ************************************************************
    // A clear borrow flag means a borrow is pending.
    assign borrow_in = ~flags_reg.borrow_out_flag;
    assign diff_wide = {1'b0, wreg_reg} - {1'b0, i_req.mem_data}
                       - {8'h00, borrow_in};
    assign low_wide = {1'b0, wreg_reg[3:0]} - {1'b0, i_req.mem_data[3:0]}
                      - {4'h0, borrow_in};
    assign diff = diff_wide[7:0];
    assign diff_null = (diff == sbd_pkg::ZERO);
    assign ovf = (wreg_reg[7] != i_req.mem_data[7]) && (diff[7] != wreg_reg[7]);

    // ************************************************************
    // Decrement
    // ************************************************************
    // Plain 8-bit subtraction wraps from zero to all ones, so a zero
    // operand never skips.
    assign dec_result = i_req.mem_data - sbd_pkg::ONE;
    assign dec_null = (dec_result == sbd_pkg::ZERO);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            SBD_SEQ_EXEC: begin
                if (take_skip) begin
                    seq_next = SBD_SEQ_DUMMY;
                end
            end
            SBD_SEQ_DUMMY: begin
                seq_next = SBD_SEQ_EXEC;
            end
            default: begin
                seq_next = SBD_SEQ_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            seq_reg <= SBD_SEQ_EXEC;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // ************************************************************
    // Working register
    // ************************************************************
    always_comb begin
        wreg_next = wreg_reg;
        if (take_dec_wreg) begin
            wreg_next = dec_result;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wreg_reg <= sbd_pkg::WREG_RESET;
        end else begin
            wreg_reg <= wreg_next;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always_comb begin
        flags_next = flags_reg;
        if (take_sub) begin
            flags_next.signed_range_error_flag = ovf;
            flags_next.result_null_flag = diff_null;
            flags_next.nibble_borrow_flag = ~low_wide[4];
            flags_next.borrow_out_flag = ~diff_wide[8];
            // Signed borrow follows the sign of the true signed result.
            flags_next.signed_borrow_flag = diff[7] ^ ovf;
            // Chained zero can only stay set across a run of zero bytes.
            flags_next.chained_zero_flag = diff_null
                && flags_reg.chained_zero_flag;
        end
        // Decrement-and-skip leaves all flags alone.
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            flags_reg <= sbd_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ************************************************************
    // Memory write-back
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_mem_wr <= '0;
        end else if (take_sub) begin
            o_mem_wr.write <= 1'b1;
            o_mem_wr.data <= diff;
        end else if (take_dec_mem) begin
            o_mem_wr.write <= 1'b1;
            o_mem_wr.data <= dec_result;
        end else begin
            // The to-register decrement never writes memory.
            o_mem_wr.write <= 1'b0;
        end
    end

    // ************************************************************
    // Skip outputs
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_skip <= 1'b0;
        end else begin
            o_skip <= take_skip;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_dummy_cycle <= 1'b0;
        end else begin
            o_dummy_cycle <= (seq_next == SBD_SEQ_DUMMY);
        end
    end

    // Busy mirrors the sequencer so the decoder upstream can hold off.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (seq_next == SBD_SEQ_DUMMY);
        end
    end

    // ************************************************************
    // Output wiring
    // ************************************************************
    assign o_working_register = wreg_reg;
    assign o_flags = flags_reg;
endmodule : sbd_core

/* File: design/sbd_pkg.sv */
// Package for the subtract-borrow and decrement-skip datapath.
package sbd_pkg;
    localparam int DATA_W = 8;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] ZERO = 8'h00;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam int FLAG_W = 6;
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [1:0] {
        SBD_OP_NONE,
        SBD_OP_SUB_BORROW_MEM,
        SBD_OP_DEC_SKIP_MEM,
        SBD_OP_DEC_SKIP_WREG
    } sbd_op_type;

    typedef struct packed {
        logic signed_range_error_flag;
        logic result_null_flag;
        logic nibble_borrow_flag;
        logic borrow_out_flag;
        logic signed_borrow_flag;
        logic chained_zero_flag;
    } sbd_flags_type;

    localparam sbd_flags_type FLAGS_RESET = 6'h00;

    typedef struct packed {
        logic valid;
        sbd_op_type op;
        logic [7:0] mem_data;
    } sbd_req_type;

    typedef struct packed {
        logic write;
        logic [7:0] data;
    } sbd_mem_wr_type;
endpackage : sbd_pkg

/* File: testbench/sbd_chk.sv */
// Checker for the sbd_core ports.
`timescale 1ns/1ps
module sbd_chk (
    input wire logic i_mclk, i_reset, o_skip, o_dummy_cycle, o_busy,
    input wire sbd_pkg::sbd_req_type i_req,
    input wire sbd_pkg::sbd_mem_wr_type o_mem_wr,
    input wire logic [7:0] o_working_register,
    input wire sbd_pkg::sbd_flags_type o_flags
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // Taken op code; a request during the dummy cycle reads as none.
    wire [1:0] tk = {2{i_req.valid & ~o_busy}} & i_req.op;
    wire [7:0] w = o_working_register, m = i_req.mem_data, d = o_mem_wr.data;
    wire c = o_flags.borrow_out_flag, b = ~c;
    sub_mem_a: assert property (tk == 2'h1 |=> o_mem_wr.write &&
        d == $past(w) - $past(m) - $past(b)) else $error("sub");
    sub_borrow_a: assert property (tk == 2'h1 |=>
        c == ({1'h0, $past(w)} >= $past(m) + $past(b))) else $error("c");
    sub_zero_a: assert property (tk == 2'h1 |=>
        o_flags.result_null_flag == (d == 8'h00)) else $error("z");
    dec_mem_a: assert property (tk == 2'h2 |=> o_mem_wr.write &&
        d == $past(m) - 8'h01 && o_skip == (d == 8'h00)) else $error("dec");
    skip_dummy_a: assert property (o_skip |-> o_dummy_cycle && o_busy
        ##1 !o_busy) else $error("dummy");
    dec_wreg_a: assert property (tk == 2'h3 |=> !o_mem_wr.write &&
        w == $past(m) - 8'h01 && o_skip == (w == 8'h00)) else $error("deca");
    dec_flags_a: assert property (tk[1] |=> $stable(o_flags))
        else $error("flags");
    sub_nibble_a: assert property (tk == 2'h1 |=>
        o_flags.nibble_borrow_flag ==
        ({1'h0, $past(w[3:0])} >= $past(m[3:0]) + $past(b))) else $error("ac");
    sub_range_a: assert property (tk == 2'h1 |=>
        o_flags.signed_range_error_flag == ($past(w[7]) != $past(m[7])
        && d[7] != $past(w[7]))) else $error("ov");
    busy_drop_a: assert property (o_busy && i_req.valid |=>
        !o_skip && !o_mem_wr.write && !o_busy) else $error("drop");
    cover property (tk == 2'h3);
    cover property (tk == 2'h1);
    cover property (o_skip);
    cover property (o_busy & i_req.valid);
endmodule : sbd_chk
bind sbd_core sbd_chk u_chk (.i_mclk, .i_reset, .i_req, .o_mem_wr,
    .o_working_register, .o_flags, .o_skip, .o_dummy_cycle, .o_busy);

/* File: testbench/test_sbd_core.sv */
// Bench for sbd_core.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t %h %h", $time, a, b); end end
module test_sbd_core;
    logic i_mclk = 1'h0, i_reset = 1'h1, o_skip, o_dummy_cycle, o_busy;
    logic [7:0] o_working_register;
    sbd_pkg::sbd_req_type i_req = '0;
    sbd_pkg::sbd_mem_wr_type o_mem_wr;
    sbd_pkg::sbd_flags_type o_flags;
    wire [11:0] got = {o_working_register, o_dummy_cycle, o_busy, o_skip,
        o_flags.borrow_out_flag};
    wire [23:0] obs = {got, 3'h0, o_mem_wr};
    int error_cnt = 0, checked = 0;
    // Op and byte, register, {dummy, busy, skip, borrow}, memory write.
    // Rows chain on the borrow flag and on the last written byte.
    logic [35:0] rows [8] = '{36'h305040000, 36'h101041102, 36'h102041102,
        36'h1050401ff, 36'h20104e100, 36'h2000401ff, 36'h30100e0ff,
        36'h300ff00ff};
    always #2 i_mclk = ~i_mclk;
    sbd_core DUT (.i_mclk, .i_reset, .i_req, .o_mem_wr, .o_working_register,
        .o_flags, .o_skip, .o_dummy_cycle, .o_busy);
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'h0;
        foreach (rows[i]) begin
            @(posedge i_mclk) i_req <= {1'h1, rows[i][33:24]};
            @(posedge i_mclk) i_req <= '0;
            #1 `CHK(obs, rows[i][23:0])
        end
        // The new to-register decrement sent during the dummy cycle must be dropped.
        @(posedge i_mclk) i_req <= 11'h601;
        @(posedge i_mclk) i_req <= 11'h710;
        #1 `CHK(obs, 24'hffe100)
        @(posedge i_mclk) i_req <= '0;
        i_reset <= 1'h1;
        #1 `CHK(obs, 24'hff0000)
        @(posedge i_mclk);
        #1 `CHK({got, o_flags}, 18'h0)
        tally_and_finish();
    end
endmodule : test_sbd_core
